/* File: hw/usb_cfg_pkg.sv */
// Package for the USB device configuration-state block.
// Assumes a single 20 MHz clock and an AXI4-Lite register master.
package usb_cfg_pkg;

  // Printed offsets are not all multiples of four, so they are register indices.
  localparam logic [15:0] MODE_STATUS_IDX = 16'hff2f;
  localparam logic [15:0] MODE_OVERRIDE_IDX = 16'hff2e;
  localparam logic [15:0] IF_RANGE_IDX = 16'hff70;
  localparam logic [15:0] SOFT_RESET_IDX = 16'hff2d;

  // Mode status field positions.
  localparam int CFG_FW_BIT = 6;
  localparam int LARGE_PKT_BIT = 4;
  localparam int DEFAULT_BIT = 3;
  localparam int CONFIGURED_BIT = 2;

  // Interface range register field positions.
  localparam int MULTI_IF_BIT = 7;
  localparam int RANGE_LSB = 0;

  // Soft reset register field position.
  localparam int SOFT_RST_BIT = 0;

  // Reset values.
  localparam logic [7:0] MODE_STATUS_RST = 8'h00;
  localparam logic [7:0] IF_RANGE_RST = 8'h00;
  localparam logic [7:0] MODE_OVERRIDE_RST = 8'h00;

  // Soft reset lands two USB clocks after the strobe ends.
  localparam logic [1:0] SOFT_RST_DELAY = 2'h2;

  // Endpoint0 small packet size in bytes.
  localparam logic [6:0] EP0_SMALL_SIZE = 7'h08;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Events from the request engine.
  typedef struct packed {
    logic bus_reset;
    logic dev_desc_done;
    logic set_config;
    logic [7:0] config_value;
  } usb_events_t;

  // Endpoint access query from the packet engine.
  typedef struct packed {
    logic [3:0] endpoint;
    logic [7:0] if_number;
  } usb_query_t;

  // Decisions back to the packet engine.
  typedef struct packed {
    logic respond_ok;
    logic endpoint_ok;
    logic if_valid;
    logic cfg_desc_to_fw;
    logic [6:0] ep0_tx_size;
  } usb_decide_t;

endpackage

/* File: hw/usb_device_config_state.sv */
// Configuration-state tracking for a USB device function controller, with AXI4-Lite registers.
// Assumes the request engine gives one-cycle event pulses on clk, and queries come on clk.
//
// Behaviour
// - Redirect bit sends config descriptor to firmware
// - Device descriptor done sets large packet flag
// - Flag clear means 8-byte Endpoint0 packets
// - Large packet flag survives bus reset
// - Before flag, automatic transfers use 8 bytes
// - Endpoint0 size eight ignores the flag
// - Bus reset sets the default state flag
// - No responses until default state flag set
// - SET_CONFIGURATION value one sets configured
// - Unconfigured device ignores non-zero endpoints
// - Config value zero or bus reset clears
// - Multi-interface enable widens supported interfaces
// - Range field ignored while enable clear
// - Range field picks highest valid interface
// - Interface zero is always valid
// - Mode status is read-only, resets to zero
// - Override register beats hardware status bits
// - Soft reset lands two clocks after strobe
module usb_device_config_state
  import usb_cfg_pkg::*;
#(
  parameter logic [6:0] EP0_MAX_SIZE = 7'h40
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire usb_events_t events,
  input wire usb_query_t query,
  output usb_decide_t decide
);

  // Address decode of a byte address to a register index match.
  function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
    hit = (addr[31:2] == {14'h0000, idx}) && (addr[1:0] == 2'h0);
  endfunction

  // Hardware-owned status flags.
  logic cfg_fw_q, cfg_fw_d;
  logic large_pkt_q, large_pkt_d;
  logic default_q, default_d;
  logic configured_q, configured_d;
  // Software registers.
  logic [7:0] if_range_q, if_range_d;
  logic [7:0] override_q;
  // Soft reset sequencing: strobe seen, then a two-clock countdown.
  logic srst_pend_q;
  logic [1:0] srst_cnt_q;
  logic srst_fire;
  // Bus slave state.
  logic aw_held_q, w_held_q;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  usb_decide_t decide_q;

  // Write channel wiring.
  wire logic aw_fire = s_axi_awvalid && !aw_held_q && !bvalid_q;
  wire logic w_fire = s_axi_wvalid && !w_held_q && !bvalid_q;
  wire logic do_write = aw_held_q && w_held_q && !bvalid_q;
  wire logic wr_lane0 = do_write && w_strb_q[0];
  wire logic wr_status = hit(aw_addr_q, MODE_STATUS_IDX);
  wire logic wr_override = hit(aw_addr_q, MODE_OVERRIDE_IDX);
  wire logic wr_range = hit(aw_addr_q, IF_RANGE_IDX);
  wire logic wr_srst = hit(aw_addr_q, SOFT_RESET_IDX);
  wire logic wr_mapped = wr_status || wr_override || wr_range || wr_srst;
  wire logic srst_strobe = wr_lane0 && wr_srst && w_data_q[SOFT_RST_BIT];

  // Read channel wiring.
  wire logic ar_fire = s_axi_arvalid && arready_q;
  wire logic rd_status = hit(s_axi_araddr, MODE_STATUS_IDX);
  wire logic rd_override = hit(s_axi_araddr, MODE_OVERRIDE_IDX);
  wire logic rd_range = hit(s_axi_araddr, IF_RANGE_IDX);
  wire logic rd_srst = hit(s_axi_araddr, SOFT_RESET_IDX);
  wire logic rd_mapped = rd_status || rd_override || rd_range || rd_srst;

  // Override beats hardware: a set override bit forces the status bit high.
  wire logic cfg_fw_eff = cfg_fw_q || override_q[CFG_FW_BIT];
  wire logic large_eff = large_pkt_q || override_q[LARGE_PKT_BIT];
  wire logic default_eff = default_q || override_q[DEFAULT_BIT];
  wire logic configured_eff = configured_q || override_q[CONFIGURED_BIT];

  // Status as software sees it; unused bits read as zero.
  wire logic [7:0] status_view = {1'b0, cfg_fw_eff, 1'b0, large_eff,
                                  default_eff, configured_eff, 2'h0};

  // The highest supported interface number.
  wire logic multi_if = if_range_q[MULTI_IF_BIT];
  wire logic [1:0] range_sel = if_range_q[RANGE_LSB +: 2];
  wire logic [7:0] if_top = multi_if ? {6'h00, range_sel} + 8'h01 : 8'h00;

  // Decisions derived from the status flags.
  wire logic ep0_is_small = (EP0_MAX_SIZE == EP0_SMALL_SIZE);
  wire logic [6:0] tx_size = (large_eff && !ep0_is_small) ? EP0_MAX_SIZE : EP0_SMALL_SIZE;
  wire logic ep_ok = default_eff && (configured_eff || query.endpoint == 4'h0);
  wire logic if_ok = (query.if_number == 8'h00) || (query.if_number <= if_top);
  wire logic set_cfg_one = events.set_config && events.config_value == 8'h01;
  wire logic set_cfg_zero = events.set_config && events.config_value == 8'h00;

  // Next values of the hardware flags.
  always_comb begin
    // The redirect flag only follows the override; hardware never sets it by itself.
    cfg_fw_d = cfg_fw_q;
    // Sticky until rst or a soft reset; a bus reset leaves it alone.
    large_pkt_d = large_pkt_q || events.dev_desc_done;
    default_d = default_q || events.bus_reset;
    configured_d = configured_q;
    if (set_cfg_one) begin
      configured_d = 1'b1;
    end
    if (set_cfg_zero || events.bus_reset) begin
      configured_d = 1'b0;
    end
    if_range_d = if_range_q;
    if (wr_lane0 && wr_range) begin
      // Middle bits are fixed at zero so they read back as zero.
      if_range_d = {w_data_q[7], 5'h00, w_data_q[1:0]};
    end
  end

  // Soft reset countdown, starting as the strobe goes inactive.
  assign srst_fire = srst_pend_q && (srst_cnt_q == 2'h1);
  always_ff @(posedge clk) begin
    if (rst || srst_fire) begin
      srst_pend_q <= 1'b0;
      srst_cnt_q <= 2'h0;
    end else if (srst_strobe) begin
      srst_pend_q <= 1'b1;
      srst_cnt_q <= SOFT_RST_DELAY;
    end else if (srst_pend_q) begin
      srst_cnt_q <= srst_cnt_q - 2'h1;
    end
  end

  // Flag and register storage; the soft reset clears all of these flags and registers, not the bus or decision state.
  always_ff @(posedge clk) begin
    if (rst || srst_fire) begin
      cfg_fw_q <= MODE_STATUS_RST[CFG_FW_BIT];
      large_pkt_q <= MODE_STATUS_RST[LARGE_PKT_BIT];
      default_q <= MODE_STATUS_RST[DEFAULT_BIT];
      configured_q <= MODE_STATUS_RST[CONFIGURED_BIT];
      if_range_q <= IF_RANGE_RST;
      override_q <= MODE_OVERRIDE_RST;
    end else begin
      cfg_fw_q <= cfg_fw_d;
      large_pkt_q <= large_pkt_d;
      default_q <= default_d;
      configured_q <= configured_d;
      if_range_q <= if_range_d;
      if (wr_lane0 && wr_override) begin
        // Bits 7 and 5 are kept zero; only bit 6 and bits 4 down to 0 are honoured.
        override_q <= {1'b0, w_data_q[6], 1'b0, w_data_q[4:0]};
      end
    end
  end

  // Decisions are registered so every decision output leaves a flip-flop.
  always_ff @(posedge clk) begin
    if (rst) begin
      decide_q <= '0;
      decide_q.ep0_tx_size <= EP0_SMALL_SIZE;
    end else begin
      decide_q.respond_ok <= default_eff;
      decide_q.endpoint_ok <= ep_ok;
      decide_q.if_valid <= if_ok;
      decide_q.cfg_desc_to_fw <= cfg_fw_eff;
      decide_q.ep0_tx_size <= tx_size;
    end
  end

  // Write address and data are held separately, taken in either order.
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // Write response; a write to the status register is accepted but ignored.
  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read path: one read in flight, answered the cycle after the address.
  always_ff @(posedge clk) begin
    if (rst) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= 32'h0000_0000;
      if (rd_status) begin
        rdata_q <= {24'h00_0000, status_view};
      end else if (rd_override) begin
        rdata_q <= {24'h00_0000, override_q};
      end else if (rd_range) begin
        rdata_q <= {24'h00_0000, if_range_q};
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign decide = decide_q;

  // Checks kept beside the logic.
  pkt_flag_set_a: assert property (@(posedge clk) disable iff (rst)
    events.dev_desc_done && !srst_fire |=> large_pkt_q)
    else $error("Packet size flag not set after descriptor");
  pkt_flag_keep_a: assert property (@(posedge clk) disable iff (rst)
    large_pkt_q && events.bus_reset && !srst_fire |=> large_pkt_q)
    else $error("Packet size flag lost on bus reset");
  default_set_a: assert property (@(posedge clk) disable iff (rst)
    events.bus_reset && !srst_fire |=> default_q)
    else $error("Default flag not set by bus reset");
  no_response_a: assert property (@(posedge clk) disable iff (rst)
    !default_eff |=> !decide.respond_ok && !decide.endpoint_ok)
    else $error("Response allowed before default state");
  config_set_a: assert property (@(posedge clk) disable iff (rst)
    set_cfg_one && !events.bus_reset && !srst_fire |=> configured_q)
    else $error("Configured flag not set");
  config_clear_a: assert property (@(posedge clk) disable iff (rst)
    events.bus_reset |=> !configured_q)
    else $error("Configured flag not cleared by bus reset");
  ep_gate_a: assert property (@(posedge clk) disable iff (rst)
    !configured_eff && query.endpoint != 4'h0 |=> !decide.endpoint_ok)
    else $error("Non-zero endpoint served while unconfigured");
  if_zero_a: assert property (@(posedge clk) disable iff (rst)
    query.if_number == 8'h00 |=> decide.if_valid)
    else $error("Interface zero rejected");
  if_single_a: assert property (@(posedge clk) disable iff (rst)
    !multi_if && query.if_number == 8'h01 |=> !decide.if_valid)
    else $error("Interface one valid while multi disabled");
  pkt_small_a: assert property (@(posedge clk) disable iff (rst)
    !large_eff |=> decide.ep0_tx_size == EP0_SMALL_SIZE)
    else $error("Large packet before flag set");
  srst_delay_a: assert property (@(posedge clk) disable iff (rst)
    srst_strobe |-> !srst_fire ##1 !srst_fire ##1 srst_fire)
    else $error("Soft reset timing wrong");
  status_ro_a: assert property (@(posedge clk) disable iff (rst)
    wr_lane0 && wr_status && !srst_fire && !events.bus_reset && !events.dev_desc_done
      && !events.set_config |=> $stable(status_view))
    else $error("Status register changed by a write");

endmodule // usb_device_config_state

/* File: verification/usb_host_model.sv */
// Behavioural model of the USB host side: request-engine events and endpoint queries.
// Assumes the bench calls its tasks from one process, clocked by the block's clk.
module usb_host_model
  import usb_cfg_pkg::*;
(
  input wire logic clk,
  output usb_events_t events,
  output usb_query_t query
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle at time zero so the block sees no stray pulses during reset.
  initial begin
    events = '0;
    query = '0;
  end

  // One-cycle pulse: 0 bus reset, 1 device descriptor done, 2 set configuration.
  // The value lines carry the inverse afterwards, so a late sample cannot pass by luck.
  task automatic send(input int kind, input logic [7:0] val);
    @(posedge clk);
    events <= {kind == 0, kind == 1, kind == 2, val};
    @(posedge clk);
    events <= {3'b000, ~val};
  endtask

  // Queries are levels and stay until the next one.
  task automatic ask(input logic [3:0] ep, input logic [7:0] num);
    @(posedge clk);
    query <= {ep, num};
  endtask
endmodule // usb_host_model

/* File: verification/tb_usb_device_config_state.sv */
// Self-checking bench: AXI4-Lite master, host model and an integer reference model.
// Assumes the design package is compiled first; all checks run on the one 20 MHz clock.
module tb_usb_device_config_state;
  import usb_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [6:0] MAXSZ = 7'h40;
  logic clk = 0;
  logic rst = 1;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rd;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0] wstrb = 4'h1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata;
  usb_events_t events;
  usb_query_t query;
  usb_decide_t decide;
  // Reference model state and counters.
  int err_total = 0, checked = 0, seed = 32'h447319a1;
  int m_default_state_flag = 0, m_large = 0, m_configured_flag = 0, m_ovr = 0, m_rng = 0, ep_q = 0, if_q = 0, lim;

  // Free-running 50 ns clock.
  initial begin
    forever #25 clk = ~clk;
  end

  usb_device_config_state #(.EP0_MAX_SIZE(MAXSZ)) DUT (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .events(events), .query(query), .decide(decide));

  usb_host_model host (.clk(clk), .events(events), .query(query));

  // One comparison; a mismatch is printed and counted at once.
  task automatic chk(input string nm, input int exp, input logic [31:0] got);
    checked++;
    if (got !== 32'(exp)) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, 32'(exp), got);
    end
  endtask

  // AXI4-Lite write; address and data offered together, each dropped when taken.
  task automatic axi_wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r);
    bit a, w, b;
    a = 1;
    w = 1;
    b = 1;
    r = 2'h3;
    @(posedge clk);
    awaddr <= {14'h0, idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int n = 0; n < 100 && b; n++) begin
      @(posedge clk);
      if (!a && !w && bvalid) begin
        b = 0;
        r = bresp;
        bready <= 0;
      end
      if (a && awready) begin
        a = 0;
        awvalid <= 0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 0;
      end
    end
    // A write that never got its response counts as a mismatch.
    chk("axi_wr_answer", 0, 32'(b));
  endtask

  // AXI4-Lite read; a missing answer leaves unknown data that fails the compare.
  task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    bit a, b;
    a = 1;
    b = 1;
    d = 'x;
    r = 2'h3;
    @(posedge clk);
    araddr <= {14'h0, idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n < 100 && b; n++) begin
      @(posedge clk);
      if (a && arready) begin
        a = 0;
        arvalid <= 0;
      end else if (!a && rvalid) begin
        b = 0;
        d = rdata;
        r = rresp;
        rready <= 0;
      end
    end
    // A read that never got its answer counts as a mismatch.
    chk("axi_rd_answer", 0, 32'(b));
  endtask

  task automatic setq(input int ep, input int n);
    host.ask(4'(ep), 8'(n));
    ep_q = ep;
    if_q = n;
  endtask

  // Compares status and every decision with the model, endpoint_ok only once the default flag is set; the read also lets decide settle.
  task automatic chk_all(input string nm);
    axi_rd(MODE_STATUS_IDX, rd, resp);
    chk("status", m_ovr | m_large * 16 | m_default_state_flag * 8 | m_configured_flag * 4, rd);
    chk("respond_ok", m_default_state_flag, 32'(decide.respond_ok));
    if (m_default_state_flag != 0) chk("endpoint_ok", ep_q == 0 || m_configured_flag != 0, 32'(decide.endpoint_ok));
    lim = (m_rng >> 7) != 0 ? (m_rng & 3) + 1 : 0;
    chk("if_valid", if_q <= lim, 32'(decide.if_valid));
    chk("cfg_desc_to_fw", (m_ovr >> 6) & 1, 32'(decide.cfg_desc_to_fw));
    chk("ep0_tx_size", m_large != 0 ? int'(MAXSZ) : 8, 32'(decide.ep0_tx_size));
    $display("test %s done, mismatches so far %0d", nm, err_total);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence: reset, events, interface ranges, override, refusals, soft reset.
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    setq(1, 0);
    chk_all("reset");
    axi_rd(IF_RANGE_IDX, rd, resp);
    chk("range_reset", 0, rd);
    host.send(0, 8'h00);
    m_default_state_flag = 1;
    chk_all("bus_reset");
    host.send(2, 8'h01);
    m_configured_flag = 1;
    chk_all("configured");
    host.send(2, 8'h00);
    m_configured_flag = 0;
    chk_all("unconfigured");
    host.send(2, 8'h01);
    host.send(0, 8'h00);
    m_configured_flag = 0;
    chk_all("reset_clears_cfg");
    host.send(1, 8'h00);
    m_large = 1;
    chk_all("large_packet");
    host.send(0, 8'h00);
    chk_all("large_kept");
    // Every enable and range pairing, with interface numbers past the top.
    for (int m = 0; m < 8; m++) begin
      m_rng = ((m >> 2) << 7) | (m & 3);
      axi_wr(IF_RANGE_IDX, 8'(m_rng), resp);
      axi_rd(IF_RANGE_IDX, rd, resp);
      chk("range", m_rng, rd);
      for (int n = 0; n < 6; n++) begin
        setq($random(seed) & 15, n);
        chk_all("interface");
      end
    end
    axi_wr(MODE_OVERRIDE_IDX, 8'h40, resp);
    m_ovr = 'h40;
    chk_all("override");
    axi_wr(MODE_STATUS_IDX, 8'hff, resp);
    chk("status_write_resp", RESP_OKAY, 32'(resp));
    chk_all("read_only");
    axi_rd(16'h0010, rd, resp);
    chk("unmapped_resp", RESP_SLVERR, 32'(resp));
    chk("unmapped_data", 0, rd);
    axi_wr(SOFT_RESET_IDX, 8'h01, resp);
    repeat (4) @(posedge clk);
    m_default_state_flag = 0;
    m_large = 0;
    m_ovr = 0;
    m_rng = 0;
    chk_all("soft_reset");
    axi_rd(IF_RANGE_IDX, rd, resp);
    chk("range_soft_reset", 0, rd);
    final_report();
  end

  // Watchdog: the sequence needs a few hundred cycles at most.
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report();
  end
endmodule // tb_usb_device_config_state
